/* psc_command_port.sv */
`timescale 1ns/1ps
module psc_command_port
    import psc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic protocol_select_pin_i,
    input wire logic chip_select_n_i,
    input wire logic spi_serial_in_i,
    output logic spi_serial_out_o,
    output logic spi_serial_out_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output psc_conv_req_type conv_req_o,
    input wire logic conv_done_i,
    input wire logic [PSC_RESULT_BITS-1:0] conv_result_i,
    input wire psc_cal_type cal_rom_i,
    output logic busy_o
);

    // ************************************************************
    // state types
    // ************************************************************

    // system clock state
    typedef struct packed {
        logic [2:0] tg_s;             // toggle from link, three stages
        logic [2:0] scl_s;            // serial clock pin, three stages
        logic [2:0] sda_s;            // data pin, three stages
        logic [2:0] ps_s;             // protocol select pin
        logic [2:0] csn_s;            // chip select pin
        logic tg_f;                   // filtered copies
        logic scl_f;
        logic sda_f;
        logic ps_f;
        logic csn_f;
        psc_i2c_st_type ist;          // i2c engine state
        logic [3:0] icnt;             // bit count in byte
        logic [7:0] ish;              // received byte
        logic [23:0] itx;             // transmit shifter
        logic iaddr;                  // receiving the address byte
        logic irw;                    // read transfer selected
        logic iack_ok;                // master acknowledged the byte
        logic idrv;                   // pull data pin low
        logic busy;                   // conversion running
        logic valid;                  // unread good result present
        logic corrupt;                // running conversion was disturbed
        logic [23:0] result;          // last conversion result
        logic [23:0] rd_word;         // word for the next i2c read
        psc_cal_type cal;             // working copy of calibration memory
        psc_conv_req_type req;        // converter request pulses
    } psc_core_type;

    // link clock state cleared at every frame edge
    typedef struct packed {
        logic [4:0] cnt;              // command bits received in the frame, stops at 8
        logic [6:0] sh;               // command bits so far
        logic [23:0] out;             // reply shifter
    } psc_link_type;

    // link clock state kept across frames
    typedef struct packed {
        logic [7:0] cmd;              // last complete command byte
        logic tgl;                    // flips once per command
    } psc_hold_type;

    psc_core_type c_q;
    psc_core_type c_d;
    psc_link_type l_q;
    psc_link_type l_d;
    psc_hold_type h_q;
    psc_hold_type h_d;

    logic link_rst;                   // frame reset for the link logic
    logic scl_rise;                   // filtered clock edges
    logic scl_fall;
    logic i2c_start;                  // bus conditions
    logic i2c_stop;
    logic cmd_ev;                     // one command to execute
    logic [7:0] cmd_byte;             // that command
    logic [7:0] spi_byte;             // byte finished on the link
    logic [23:0] spi_reply;           // reply loaded on the link

    // ************************************************************
    // spi link logic on the serial clock
    // ************************************************************

    // deselect or i2c mode holds the frame logic cleared
    // deselect clears frame
    assign link_rst = sys_rst_i | chip_select_n_i | protocol_select_pin_i;

    // both modes sample on the rising edge, so one process serves both
    always_comb begin
        l_d = l_q;
        h_d = h_q;
        spi_byte = {l_q.sh, spi_serial_in_i};
        spi_reply = PSC_RESULT_RST;
        if (spi_byte == PSC_CMD_ADC_READ) begin
            if (c_q.valid && !c_q.busy) begin
                spi_reply = c_q.result;
            end
        end else if (spi_byte[7:4] == PSC_CMD_CALIBRATION_MEMORY_HI && !spi_byte[0]) begin
            spi_reply = {c_q.cal[spi_byte[3:1]], 8'h00};
        end
        if (l_q.cnt < PSC_SPI_CMD_BITS) begin
            // command phase
            l_d.sh = spi_byte[6:0];
            l_d.cnt = l_q.cnt + 5'h01;
            if (l_q.cnt == PSC_SPI_CMD_BITS - 5'h01) begin
                h_d.cmd = spi_byte;
                h_d.tgl = ~h_q.tgl;
                l_d.out = spi_reply;
            end
        end else begin
            l_d.out = {l_q.out[22:0], 1'b0};
        end
    end

    // frame registers
    // both modes served
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // command holding register survives the frame end
    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    // output bit and its enable
    assign spi_serial_out_o = l_q.out[23];
    assign spi_serial_out_oe_o = ~chip_select_n_i & ~protocol_select_pin_i;

    // ************************************************************
    // system clock logic: synchronisers, i2c engine, execution
    // ************************************************************

    always_comb begin
        c_d = c_q;
        // pulses last one cycle
        c_d.req.start = 1'b0;
        c_d.req.abort = 1'b0;

        // synchroniser chains, first stage read only by the second
        c_d.tg_s = {c_q.tg_s[1:0], h_q.tgl};
        c_d.scl_s = {c_q.scl_s[1:0], sclk_i};
        c_d.sda_s = {c_q.sda_s[1:0], spi_serial_in_i};
        c_d.ps_s = {c_q.ps_s[1:0], protocol_select_pin_i};
        c_d.csn_s = {c_q.csn_s[1:0], chip_select_n_i};
        // a change counts once the second and third stages agree
        if (c_q.tg_s[1] == c_q.tg_s[2]) begin
            c_d.tg_f = c_q.tg_s[2];
        end
        if (c_q.scl_s[1] == c_q.scl_s[2]) begin
            c_d.scl_f = c_q.scl_s[2];
        end
        if (c_q.sda_s[1] == c_q.sda_s[2]) begin
            c_d.sda_f = c_q.sda_s[2];
        end
        if (c_q.ps_s[1] == c_q.ps_s[2]) begin
            c_d.ps_f = c_q.ps_s[2];
        end
        if (c_q.csn_s[1] == c_q.csn_s[2]) begin
            c_d.csn_f = c_q.csn_s[2];
        end

        // edges and bus conditions of the filtered lines
        scl_rise = c_d.scl_f & ~c_q.scl_f;
        scl_fall = ~c_d.scl_f & c_q.scl_f;
        i2c_start = c_q.scl_f & c_d.scl_f & c_q.sda_f & ~c_d.sda_f;
        i2c_stop = c_q.scl_f & c_d.scl_f & ~c_q.sda_f & c_d.sda_f;

        // spi commands arrive as a toggle
        cmd_ev = (c_d.tg_f != c_q.tg_f) & ~c_q.ps_f;
        cmd_byte = h_q.cmd;

        // ---------------- i2c engine ----------------
        if (!c_q.ps_f) begin
            // spi mode keeps the engine parked
            c_d.ist = PSC_I_IDLE;
            c_d.idrv = 1'b0;
        end else if (i2c_start) begin
            // start, also repeated start, opens an address byte
            c_d.ist = PSC_I_RX;
            c_d.icnt = 4'h0;
            c_d.iaddr = 1'b1;
            c_d.idrv = 1'b0;
        end else if (i2c_stop) begin
            // stop ends any transfer
            c_d.ist = PSC_I_IDLE;
            c_d.idrv = 1'b0;
        end else begin
            case (c_q.ist)
                PSC_I_RX: begin
                    if (scl_rise && c_q.icnt < PSC_I2C_BYTE_BITS) begin
                        c_d.ish = {c_q.ish[6:0], c_q.sda_f};
                        c_d.icnt = c_q.icnt + 4'h1;
                    end else if (scl_fall && c_q.icnt == PSC_I2C_BYTE_BITS) begin
                        if (c_q.iaddr) begin
                            if (c_q.ish[7:1] == {PSC_I2C_ADDR_HI, ~c_q.csn_f}) begin
                                c_d.ist = PSC_I_ACK;
                                c_d.idrv = 1'b1;
                                c_d.irw = c_q.ish[0];
                            end else begin
                                c_d.ist = PSC_I_IDLE;
                            end
                        end else begin
                            // command byte goes to execution
                            cmd_ev = 1'b1;
                            cmd_byte = c_q.ish;
                            c_d.ist = PSC_I_ACK;
                            c_d.idrv = 1'b1;
                        end
                    end
                end
                PSC_I_ACK: begin
                    if (scl_fall) begin
                        c_d.icnt = 4'h0;
                        if (c_q.irw) begin
                            c_d.ist = PSC_I_TX;
                            c_d.itx = c_q.rd_word;
                            c_d.idrv = ~c_q.rd_word[23];
                        end else begin
                            c_d.ist = PSC_I_RX;
                            c_d.iaddr = 1'b0;
                            c_d.idrv = 1'b0;
                        end
                    end
                end
                PSC_I_TX: begin
                    if (scl_rise) begin
                        c_d.itx = {c_q.itx[22:0], 1'b0};
                        c_d.icnt = c_q.icnt + 4'h1;
                    end else if (scl_fall) begin
                        if (c_q.icnt == PSC_I2C_BYTE_BITS) begin
                            // release for the master acknowledge
                            c_d.ist = PSC_I_MACK;
                            c_d.idrv = 1'b0;
                        end else begin
                            c_d.idrv = ~c_q.itx[23];
                        end
                    end
                end
                PSC_I_MACK: begin
                    if (scl_rise) begin
                        c_d.iack_ok = ~c_q.sda_f;
                    end else if (scl_fall) begin
                        c_d.icnt = 4'h0;
                        if (c_q.iack_ok) begin
                            c_d.ist = PSC_I_TX;
                            c_d.idrv = ~c_q.itx[23];
                        end else begin
                            c_d.ist = PSC_I_IDLE;
                        end
                    end
                end
                default: begin
                    c_d.idrv = 1'b0;
                end
            endcase
        end

        // ---------------- conversion completion ----------------
        // busy until done
        if (c_q.busy && conv_done_i) begin
            c_d.busy = 1'b0;
            c_d.result = conv_result_i;
            c_d.valid = ~c_q.corrupt;
        end

        // ---------------- command execution ----------------
        if (cmd_ev) begin
            if (cmd_byte == PSC_CMD_RESET) begin
                c_d.req.abort = 1'b1;
                c_d.busy = 1'b0;
                c_d.valid = 1'b0;
                c_d.corrupt = 1'b0;
                c_d.rd_word = PSC_RESULT_RST;
                c_d.cal = cal_rom_i;
            end else if (cmd_byte == PSC_CMD_ADC_READ) begin
                c_d.rd_word = (c_q.valid && !c_q.busy) ? c_q.result : PSC_RESULT_RST;
                c_d.valid = 1'b0;
                if (c_q.busy) begin
                    c_d.corrupt = 1'b1;
                end
            end else if (cmd_byte[7:4] == PSC_CMD_CALIBRATION_MEMORY_HI && !cmd_byte[0]) begin
                c_d.rd_word = {c_q.cal[cmd_byte[3:1]], 8'h00};
            end else if (cmd_byte[7:5] == PSC_CMD_CONV_HI && !cmd_byte[0]
                         && cmd_byte[3:1] <= PSC_OSR_MAX_INDEX) begin
                if (c_q.busy) begin
                    c_d.corrupt = 1'b1;
                end else begin
                    c_d.req.start = 1'b1;
                    c_d.req.kind_temp = cmd_byte[4];
                    c_d.req.osr_index = cmd_byte[3:1];
                    c_d.busy = 1'b1;
                    c_d.valid = 1'b0;
                    c_d.corrupt = 1'b0;
                end
            end
        end
    end

    // system clock registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // open-drain data pin only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = c_q.idrv;
    assign conv_req_o = c_q.req;
    assign busy_o = c_q.busy;

endmodule : psc_command_port

/* psc_pkg.sv */
package psc_pkg;

    // ************************************************************
    // sizes of result and calibration memory
    // ************************************************************
    localparam int unsigned PSC_RESULT_BITS = 24;
    localparam int unsigned PSC_CAL_WORD_BITS = 16;
    localparam int unsigned PSC_CAL_WORDS = 8;

    // ************************************************************
    // calibration memory word offsets
    // ************************************************************
    localparam logic [2:0] PSC_FACTORY_SETUP_WORD_OFS = 3'h0;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_ONE_OFS = 3'h1;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_TWO_OFS = 3'h2;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_THREE_OFS = 3'h3;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_FOUR_OFS = 3'h4;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_FIVE_OFS = 3'h5;
    localparam logic [2:0] PSC_CALIBRATION_COEFF_SIX_OFS = 3'h6;
    localparam logic [2:0] PSC_SERIAL_AND_CHECKSUM_WORD_OFS = 3'h7;
    // checksum field inside the last word
    localparam int unsigned PSC_CRC_LSB = 0;
    localparam int unsigned PSC_CRC_BITS = 4;

    // ************************************************************
    // command encodings
    // ************************************************************
    localparam logic [7:0] PSC_CMD_RESET = 8'h1e;
    localparam logic [7:0] PSC_CMD_ADC_READ = 8'h00;
    localparam logic [3:0] PSC_CMD_CALIBRATION_MEMORY_HI = 4'ha;
    localparam logic [2:0] PSC_CMD_CONV_HI = 3'h2;
    localparam logic [2:0] PSC_OSR_MAX_INDEX = 3'h4;

    // ************************************************************
    // link constants and reset values
    // ************************************************************
    localparam logic [5:0] PSC_I2C_ADDR_HI = 6'h3b;
    localparam logic [4:0] PSC_SPI_CMD_BITS = 5'h08;
    localparam logic [3:0] PSC_I2C_BYTE_BITS = 4'h8;
    localparam logic [23:0] PSC_RESULT_RST = 24'h000000;
    localparam logic [7:0] PSC_CMD_RST = 8'h00;

    // ************************************************************
    // types
    // ************************************************************
    typedef logic [PSC_CAL_WORDS-1:0][PSC_CAL_WORD_BITS-1:0] psc_cal_type;

    // request towards the converter core
    typedef struct packed {
        logic start;
        logic abort;
        logic kind_temp;
        logic [2:0] osr_index;
    } psc_conv_req_type;

    typedef enum logic [2:0] {
        PSC_I_IDLE,
        PSC_I_RX,
        PSC_I_ACK,
        PSC_I_TX,
        PSC_I_MACK
    } psc_i2c_st_type;

endpackage : psc_pkg

/* psc_checker.sv */
`timescale 1ns/1ps
// ************************************************************
// port checker for the command port
// ************************************************************
module psc_checker
    import psc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic protocol_select_pin_i,
    input wire logic chip_select_n_i,
    input wire logic spi_serial_in_i,
    input wire logic spi_serial_out_o,
    input wire logic spi_serial_out_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire psc_conv_req_type conv_req_o,
    input wire logic conv_done_i,
    input wire logic [PSC_RESULT_BITS-1:0] conv_result_i,
    input wire psc_cal_type cal_rom_i,
    input wire logic busy_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // start pulse and busy rise together, then a running cycle with no second pulse
    sequence s_start_to_busy;
        conv_req_o.start && busy_o ##1 busy_o && !conv_req_o.start;
    endsequence

    a_start_sets_busy: assert property (conv_req_o.start |-> s_start_to_busy)
        else $error("conversion start did not raise busy");
    a_done_ends_busy: assert property (busy_o && conv_done_i |=> !busy_o)
        else $error("busy stayed after conversion done");
    a_busy_end_cause: assert property ($fell(busy_o) |->
        $past(conv_done_i) || $past(conv_req_o.abort) || conv_req_o.abort)
        else $error("busy fell without done or abort");
    a_busy_deselected: assert property (busy_o && chip_select_n_i && !conv_done_i
        && !conv_req_o.abort |=> busy_o || conv_req_o.abort)
        else $error("conversion dropped while deselected");
    a_abort_idles: assert property (conv_req_o.abort |-> ##[0:1] !busy_o)
        else $error("abort left the core busy");
    a_osr_in_range: assert property (conv_req_o.start |=>
        conv_req_o.osr_index <= PSC_OSR_MAX_INDEX)
        else $error("oversampling index out of range");
    a_oe_follows_pins: assert property (spi_serial_out_oe_o ==
        (!chip_select_n_i && !protocol_select_pin_i))
        else $error("serial output enable wrong for pins");
    a_sda_quiet_spi: assert property (!protocol_select_pin_i [*8] |-> !sda_oe_o)
        else $error("sda pulled while in spi mode");
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("sda driven high");
endmodule : psc_checker

/* psc_host_model.sv */
`timescale 1ns/1ps
// ************************************************************
// host master model driving spi or i2c frames
// ************************************************************
module psc_host_model (
    output logic sclk_o,
    output logic csn_o,
    output logic ps_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sda_i,
    input wire logic sda_oe_i
);
    logic sdi_q = 1'b0; // spi data from host
    logic sda_h = 1'b1; // host side of sda, 0 pulls low
    logic sda_w; // resolved sda with pull-up
    assign sda_w = sda_h & ~(sda_oe_i & ~sda_i);
    // data pin carries sda in i2c mode
    assign sdi_o = ps_o ? sda_w : sdi_q;
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        ps_o = 1'b0;
    end
    // one spi frame: command msb first, then 24 reply bits; clock still outside
    task automatic spi(input logic [7:0] cmd, input logic mode3, output logic [23:0] rep);
        logic [31:0] sh;
        sh = {cmd, 24'h000000};
        sclk_o <= mode3;
        #10;
        csn_o <= 1'b0;
        #32;
        for (int i = 0; i < 32; i++) begin
            sclk_o <= 1'b0;
            sdi_q <= sh[31-i];
            #32;
            rep = {rep[22:0], sdo_i};
            sclk_o <= 1'b1;
            #32;
        end
        sclk_o <= mode3;
        #32;
        csn_o <= 1'b1;
        // idle data never shows its last value
        sdi_q <= ~sdi_q;
        // select stays high a while before any next frame
        #32;
    endtask : spi
    task automatic junk(input int n);
        for (int i = 0; i < n; i++) begin
            sdi_q <= i[0];
            sclk_o <= 1'b1;
            #32;
            sclk_o <= 1'b0;
            #32;
        end
    endtask : junk
    task automatic set_i2c(input logic on);
        ps_o <= on;
        csn_o <= ~on;
        sclk_o <= on;
        #64;
    endtask : set_i2c
    // one scl period, sampling sda while scl high
    task automatic i2c_bit(input logic b, output logic s);
        sda_h <= b;
        #48;
        sclk_o <= 1'b1;
        #32;
        s = sda_w;
        #32;
        sclk_o <= 1'b0;
        #16;
    endtask : i2c_bit
    task automatic i2c_edge(input logic stop);
        sda_h <= stop ? 1'b0 : 1'b1;
        #48;
        sclk_o <= 1'b1;
        #64;
        sda_h <= stop;
        #64;
        if (!stop) begin
            sclk_o <= 1'b0;
            #16;
        end
    endtask : i2c_edge
    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 0; i < 8; i++) begin
            i2c_bit(b[7-i], s);
        end
        i2c_bit(1'b1, s);
        ack = ~s;
    endtask : i2c_byte
    task automatic i2c_wr(input logic [6:0] adr, input logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        i2c_edge(1'b0);
        i2c_byte({adr, 1'b0}, a1);
        i2c_byte(d, a2);
        i2c_edge(1'b1);
        ack = a1 & a2;
    endtask : i2c_wr
    // eight clocks per byte, host ack between, nack on the last
    task automatic i2c_rd(input logic [6:0] adr, input int n, output logic [23:0] v);
        logic s;
        i2c_edge(1'b0);
        i2c_byte({adr, 1'b1}, s);
        v = 24'h000000;
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j < 8; j++) begin
                i2c_bit(1'b1, s);
                v = {v[22:0], s};
            end
            i2c_bit(i == n - 1, s);
        end
        i2c_edge(1'b1);
    endtask : i2c_rd
endmodule : psc_host_model

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin cmp_count++; if ((act) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end
// ************************************************************
// bench top: clock, reset, converter stub, sequences
// ************************************************************
module tb_top
    import psc_pkg::*;
;
    localparam int CONV_CYC = 1500; // converter stub length in mclk
    localparam logic [23:0] RES_BASE = 24'h9c36a1; // stub result pattern
    localparam psc_cal_type CAL = {16'h3c5a, 16'h8e17, 16'h52d9, 16'hb0c4,
        16'h6f23, 16'hd18b, 16'h47e6, 16'h0f1e}; // word 0 on the right
    logic mclk_i;
    logic sys_rst_i = 1'b1;
    logic sclk, csn, ps, spi_serial_in, spi_serial_out, sdo_oe, sda, sda_oe, busy;
    psc_conv_req_type conv_req;
    logic conv_done = 1'b0;
    logic conv_run = 1'b0;
    logic [23:0] conv_result = 24'h000000;
    int conv_cnt = 0;
    int fail_count = 0;
    int cmp_count = 0;
    logic [23:0] rep;
    logic [7:0] cmd;
    logic ack;

    psc_command_port i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .protocol_select_pin_i(ps), .chip_select_n_i(csn), .spi_serial_in_i(spi_serial_in),
        .spi_serial_out_o(spi_serial_out), .spi_serial_out_oe_o(sdo_oe), .sda_o(sda),
        .sda_oe_o(sda_oe), .conv_req_o(conv_req), .conv_done_i(conv_done),
        .conv_result_i(conv_result), .cal_rom_i(CAL), .busy_o(busy));
    psc_host_model i_host (.sclk_o(sclk), .csn_o(csn), .ps_o(ps), .sdi_o(spi_serial_in),
        .sdo_i(spi_serial_out), .sda_i(sda), .sda_oe_i(sda_oe));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // converter stub: result encodes the requested kind and ratio
    always @(posedge mclk_i) begin
        conv_done <= 1'b0;
        if (sys_rst_i || conv_req.abort) begin
            conv_run <= 1'b0;
        end else if (conv_req.start) begin
            conv_run <= 1'b1;
            conv_cnt <= 0;
        end else if (conv_run) begin
            conv_cnt <= conv_cnt + 1;
            conv_result <= RES_BASE ^ {16'h0000, 3'b010, conv_req.kind_temp,
                conv_req.osr_index, 1'b0};
            if (conv_cnt == CONV_CYC) begin
                conv_done <= 1'b1;
                conv_run <= 1'b0;
            end
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic gap();
        repeat (12) @(posedge mclk_i);
        #1;
    endtask : gap
    // bounded wait for the conversion to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            $display("mismatch at %0t: conversion never ends", $time);
            end_sim();
        end
        gap();
    endtask : wait_idle
    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        gap();
        i_host.spi({PSC_CMD_CALIBRATION_MEMORY_HI, 3'h1, 1'b0}, 1'b0, rep);
        `CHK(rep, 24'h000000, "cal before reset command")
        i_host.spi(PSC_CMD_RESET, 1'b1, rep);
        gap();
        for (int w = 0; w < 8; w++) begin
            i_host.spi({PSC_CMD_CALIBRATION_MEMORY_HI, 3'(w), 1'b0}, 1'(w), rep);
            `CHK(rep, {CAL[w], 8'h00}, "cal word")
        end
        i_host.spi(PSC_CMD_ADC_READ, 1'b0, rep);
        `CHK(rep, 24'h000000, "read without conversion")
        $display("test done: calibration");
        for (int k = 0; k < 10; k++) begin
            cmd = {3'b010, 1'(k / 5), 3'(k % 5), 1'b0};
            i_host.spi(cmd, 1'(k), rep);
            gap();
            `CHK(busy, 1'b1, "busy while deselected")
            wait_idle();
            i_host.spi(PSC_CMD_ADC_READ, 1'(k), rep);
            `CHK(rep, RES_BASE ^ {16'h0000, cmd}, "conversion result")
            i_host.spi(PSC_CMD_ADC_READ, 1'(k + 1), rep);
            `CHK(rep, 24'h000000, "repeated read")
        end
        $display("test done: conversions");
        i_host.spi(8'h44, 1'b0, rep);
        i_host.spi(PSC_CMD_ADC_READ, 1'b0, rep);
        `CHK(rep, 24'h000000, "read while busy")
        `CHK(busy, 1'b1, "conversion goes on")
        wait_idle();
        i_host.spi(PSC_CMD_ADC_READ, 1'b1, rep);
        `CHK(rep, 24'h000000, "spoiled result")
        i_host.spi(8'h52, 1'b1, rep);
        wait_idle();
        i_host.spi(8'h33, 1'b0, rep);
        `CHK(rep, 24'h000000, "unknown command reply")
        i_host.spi(PSC_CMD_ADC_READ, 1'b0, rep);
        `CHK(rep, RES_BASE ^ 24'h000052, "result after unknown")
        i_host.spi(8'h58, 1'b0, rep);
        i_host.spi(PSC_CMD_RESET, 1'b1, rep);
        gap();
        `CHK(busy, 1'b0, "reset stops conversion")
        i_host.spi(PSC_CMD_ADC_READ, 1'b0, rep);
        `CHK(rep, 24'h000000, "result cleared by reset")
        i_host.junk(16);
        `CHK(sdo_oe, 1'b0, "output released")
        i_host.spi({PSC_CMD_CALIBRATION_MEMORY_HI, 3'h3, 1'b0}, 1'b1, rep);
        `CHK(rep, {CAL[3], 8'h00}, "word after stray clocks")
        $display("test done: spi corner cases");
        i_host.set_i2c(1'b1);
        gap();
        i_host.i2c_wr(7'h76, PSC_CMD_RESET, ack);
        `CHK(ack, 1'b0, "foreign address")
        i_host.i2c_wr(7'h77, 8'h48, ack);
        `CHK(ack, 1'b1, "own address")
        wait_idle();
        i_host.i2c_wr(7'h77, PSC_CMD_ADC_READ, ack);
        i_host.i2c_rd(7'h77, 3, rep);
        `CHK(rep, RES_BASE ^ 24'h000048, "i2c result")
        i_host.i2c_wr(7'h77, {PSC_CMD_CALIBRATION_MEMORY_HI, 3'h6, 1'b0}, ack);
        i_host.i2c_rd(7'h77, 2, rep);
        `CHK(rep[15:0], CAL[6], "i2c cal word")
        i_host.set_i2c(1'b0);
        gap();
        $display("test done: i2c");
        end_sim();
    end
endmodule : tb_top
bind psc_command_port psc_checker i_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i), .protocol_select_pin_i(protocol_select_pin_i),
    .chip_select_n_i(chip_select_n_i), .spi_serial_in_i(spi_serial_in_i),
    .spi_serial_out_o(spi_serial_out_o), .spi_serial_out_oe_o(spi_serial_out_oe_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_req_o(conv_req_o),
    .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .cal_rom_i(cal_rom_i), .busy_o(busy_o));
